// file: logic/aperture_swap.sv
`timescale 1ns/1ns
`default_nettype none
`include "pel_cfg.svh"
module aperture_swap
  import pel_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  apt_if.conv fmt,
  input wire logic wr_in_valid,
  input wire logic [31:0] wr_in_data,
  output logic wr_out_valid,
  output logic [31:0] wr_out_data,
  input wire logic rd_in_valid,
  input wire logic [31:0] rd_in_data,
  output logic rd_out_valid,
  output logic [31:0] rd_out_data
);
  logic wr_valid_r, wr_valid_nxt, rd_valid_r, rd_valid_nxt;
  logic [31:0] wr_data_r, wr_data_nxt, rd_data_r, rd_data_nxt;

  // Same reordering both ways: it is its own inverse
  function automatic logic [31:0] convert(input logic [31:0] d, input logic big,
                                          input logic [2:0] depth);
    logic [31:0] r;
    logic [7:0] b;
    r = d;
    if (big) begin
      if (depth == `DEPTH_16) begin
        r = {d[23:16], d[31:24], d[7:0], d[15:8]};
      end else begin
        for (int i = 0; i < 4; i++) begin
          b = d[8*i +: 8];
          if (depth == `DEPTH_1) begin
            b = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
          end else if (depth == `DEPTH_2) begin
            b = {b[1:0], b[3:2], b[5:4], b[7:6]};
          end else if (depth == `DEPTH_4) begin
            b = {b[3:0], b[7:4]};
          end
          r[8*(3-i) +: 8] = b;
        end
      end
    end
    return r;
  endfunction

  always_comb begin
    wr_valid_nxt = wr_in_valid;
    rd_valid_nxt = rd_in_valid;
    wr_data_nxt = wr_data_r;
    rd_data_nxt = rd_data_r;
    if (wr_in_valid) begin
      wr_data_nxt = convert(wr_in_data, fmt.big_endian, fmt.pel_depth);
    end
    if (rd_in_valid) begin
      rd_data_nxt = convert(rd_in_data, fmt.big_endian, fmt.pel_depth);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_valid_r <= 1'b0;
      rd_valid_r <= 1'b0;
      wr_data_r <= 32'h0000_0000;
      rd_data_r <= 32'h0000_0000;
    end else begin
      wr_valid_r <= wr_valid_nxt;
      rd_valid_r <= rd_valid_nxt;
      wr_data_r <= wr_data_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign wr_out_valid = wr_valid_r;
  assign wr_out_data = wr_data_r;
  assign rd_out_valid = rd_valid_r;
  assign rd_out_data = rd_data_r;

  chk_apt_little_pass: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_in_valid && !fmt.big_endian |=> wr_out_valid && wr_out_data == $past(wr_in_data))
    else $error("Little-endian aperture write altered");
  chk_apt_big_8bpp: assert property (@(posedge core_clk) disable iff (!reset_n)
    rd_in_valid && fmt.big_endian && fmt.pel_depth == `DEPTH_8
    |=> rd_out_valid && rd_out_data[7:0] == $past(rd_in_data[31:24]))
    else $error("Big-endian aperture read not byte swapped");
endmodule
`default_nettype wire

// file: logic/pel_operation_decoder.sv
// Behaviour
// - 32-bit command word with fixed fields
// - Background from color 00, source map 10
// - Foreground from color 00, source map 10
// - Step field selects the operation type
// - Source map select A/B/C by 1/2/3
// - Destination map select A/B/C by 1/2/3
// - Pattern map A/B/C, fixed foreground, from source
// - Map setup independent; selection applies on load
// - Mask off, boundary, or full mask map
// - Line: all pels, first null, last null
// - Mode 11 draws area-fill outlines
// - Octant bits: negative X, negative Y, swap
// - Normalized steps mapped back to real direction
// - Aperture format register controls host accesses
// - Memory little-endian; big-endian accesses reordered
// - Map byte-order applies only in system memory
// - Conversion uses current setting on every access
`timescale 1ns/1ns
`default_nettype none
`include "pel_cfg.svh"
module pel_operation_decoder
  import pel_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic op_done,
  output logic op_start,
  output logic busy,
  output var src_e bg_source,
  output var src_e fg_source,
  output var op_e step_op,
  output var map_e src_map,
  output var map_e dst_map,
  output var pat_e pat_map,
  output var mask_e mask_mode,
  output var draw_e draw_mode,
  output logic negative_x_flag,
  output logic negative_y_flag,
  output logic axis_swap_flag,
  output logic src_fmt_big,
  output logic dst_fmt_big,
  output logic pat_fmt_big,
  input wire logic norm_step_valid,
  input wire logic norm_step_minor,
  output logic step_valid,
  output logic step_move_x,
  output logic step_move_y,
  output logic step_x_neg,
  output logic step_y_neg,
  input wire logic apt_wr_valid,
  input wire logic [31:0] apt_wr_data,
  output logic vm_wr_valid,
  output logic [31:0] vm_wr_data,
  input wire logic vm_rd_valid,
  input wire logic [31:0] vm_rd_data,
  output logic apt_rd_valid,
  output logic [31:0] apt_rd_data
);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic src_e dec_src(input logic [1:0] c);
    if (c == `SRC_CODE_COLOR) begin
      return SRC_COLOR;
    end else if (c == `SRC_CODE_MAP) begin
      return SRC_MAP;
    end
    return SRC_BAD;
  endfunction

  function automatic map_e dec_map(input logic [3:0] c);
    case (c)
      `MAP_CODE_A: return MAP_A;
      `MAP_CODE_B: return MAP_B;
      `MAP_CODE_C: return MAP_C;
      default: return MAP_NONE;
    endcase
  endfunction

  // Map location flag: byte order matters only for system-memory maps
  function automatic logic map_big(input logic [1:0] idx, input logic [7:0] loc);
    if (idx == 2'h0) begin
      return 1'b0;
    end
    return loc[`MAPLOC_SYS_LO + idx - 1] & loc[`MAPLOC_BIG_LO + idx - 1];
  endfunction

  function automatic logic [1:0] map_idx(input map_e m);
    case (m)
      MAP_A: return 2'h1;
      MAP_B: return 2'h2;
      MAP_C: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction

  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] cmd_r, cmd_nxt;
  logic [7:0] apt_r, apt_nxt, maploc_r, maploc_nxt;
  logic acc, cmd_wr;
  run_e state_r, state_nxt;
  logic start_r, start_nxt, bad_r, bad_nxt;
  src_e bg_r, bg_nxt, fg_r, fg_nxt;
  op_e op_r, op_nxt;
  map_e srcm_r, srcm_nxt, dstm_r, dstm_nxt;
  pat_e pat_r, pat_nxt;
  mask_e mask_r, mask_nxt;
  draw_e draw_r, draw_nxt;
  logic [2:0] oct_r, oct_nxt;
  logic [2:0] fmt_r, fmt_nxt;
  logic [4:0] step_r, step_nxt;
  apt_if apt ();

  // One wait cycle gives a registered read path
  assign waitrequest = (read | write) & ~ack_r;
  assign acc = (read | write) & ack_r;
  assign cmd_wr = acc & write & (address == ADDR_W'(`OFS_CMD));

  always_comb begin
    ack_nxt = (read | write) & ~ack_r;
    rdata_nxt = rdata_r;
    cmd_nxt = cmd_r;
    apt_nxt = apt_r;
    maploc_nxt = maploc_r;
    if ((read | write) && !ack_r) begin
      rdata_nxt = 32'h0000_0000;
      if (read) begin
        case (address)
          ADDR_W'(`OFS_CMD): rdata_nxt = cmd_r;
          ADDR_W'(`OFS_APT): rdata_nxt = {24'h00_0000, apt_r};
          ADDR_W'(`OFS_MAPLOC): rdata_nxt = {24'h00_0000, maploc_r};
          ADDR_W'(`OFS_STATUS): begin
            rdata_nxt[`STAT_BUSY] = (state_r == ST_RUN);
            rdata_nxt[`STAT_BAD] = bad_r;
          end
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    if (acc && write) begin
      case (address)
        ADDR_W'(`OFS_CMD): cmd_nxt = merge(cmd_r, writedata, byteenable);
        ADDR_W'(`OFS_APT): apt_nxt = 8'(merge({24'h00_0000, apt_r}, writedata,
                                              byteenable));
        ADDR_W'(`OFS_MAPLOC): maploc_nxt = 8'(merge({24'h00_0000, maploc_r}, writedata,
                                                    byteenable));
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      cmd_r <= `CMD_RESET;
      apt_r <= `APT_RESET;
      maploc_r <= `MAPLOC_RESET;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      cmd_r <= cmd_nxt;
      apt_r <= apt_nxt;
      maploc_r <= maploc_nxt;
    end
  end

  // Decoded fields only change on a command load
  always_comb begin
    bg_nxt = bg_r;
    fg_nxt = fg_r;
    op_nxt = op_r;
    srcm_nxt = srcm_r;
    dstm_nxt = dstm_r;
    pat_nxt = pat_r;
    mask_nxt = mask_r;
    draw_nxt = draw_r;
    oct_nxt = oct_r;
    bad_nxt = bad_r;
    if (cmd_wr) begin
      bg_nxt = dec_src(cmd_nxt[`CMD_BG_HI:`CMD_BG_LO]);
      fg_nxt = dec_src(cmd_nxt[`CMD_FG_HI:`CMD_FG_LO]);
      case (cmd_nxt[`CMD_STEP_HI:`CMD_STEP_LO])
        `STEP_DSR: op_nxt = OP_DSR;
        `STEP_LDR: op_nxt = OP_LDR;
        `STEP_DSW: op_nxt = OP_DSW;
        `STEP_LDW: op_nxt = OP_LDW;
        `STEP_BLT: op_nxt = OP_BLT;
        `STEP_INV: op_nxt = OP_INV;
        `STEP_FILL: op_nxt = OP_FILL;
        default: op_nxt = OP_NONE;
      endcase
      srcm_nxt = dec_map(cmd_nxt[`CMD_SRC_HI:`CMD_SRC_LO]);
      dstm_nxt = dec_map(cmd_nxt[`CMD_DST_HI:`CMD_DST_LO]);
      case (cmd_nxt[`CMD_PAT_HI:`CMD_PAT_LO])
        `MAP_CODE_A: pat_nxt = PAT_A;
        `MAP_CODE_B: pat_nxt = PAT_B;
        `MAP_CODE_C: pat_nxt = PAT_C;
        `PAT_CODE_FG: pat_nxt = PAT_FG;
        `PAT_CODE_SRC: pat_nxt = PAT_SRC;
        default: pat_nxt = PAT_NONE;
      endcase
      case (cmd_nxt[`CMD_MASK_HI:`CMD_MASK_LO])
        `MASK_CODE_OFF: mask_nxt = MASK_OFF;
        `MASK_CODE_BOUND: mask_nxt = MASK_BOUND;
        `MASK_CODE_ON: mask_nxt = MASK_ON;
        default: mask_nxt = MASK_BAD;
      endcase
      case (cmd_nxt[`CMD_DRAW_HI:`CMD_DRAW_LO])
        `DRAW_CODE_ALL: draw_nxt = DRAW_ALL;
        `DRAW_CODE_FIRST: draw_nxt = DRAW_FIRST_NULL;
        `DRAW_CODE_LAST: draw_nxt = DRAW_LAST_NULL;
        default: draw_nxt = DRAW_OUTLINE;
      endcase
      // Bits 11:8 and 3 never reach any decode
      oct_nxt = {cmd_nxt[`CMD_NEG_X], cmd_nxt[`CMD_NEG_Y], cmd_nxt[`CMD_SWAP]};
      // Reserved codes are flagged, not trusted; map fields too
      bad_nxt = (dec_map(cmd_nxt[`CMD_SRC_HI:`CMD_SRC_LO]) == MAP_NONE) ||
                (dec_map(cmd_nxt[`CMD_DST_HI:`CMD_DST_LO]) == MAP_NONE) ||
                (pat_nxt == PAT_NONE) || (mask_nxt == MASK_BAD) ||
                (op_nxt == OP_NONE) || (bg_nxt == SRC_BAD) || (fg_nxt == SRC_BAD);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bg_r <= SRC_COLOR;
      fg_r <= SRC_COLOR;
      op_r <= OP_NONE;
      srcm_r <= MAP_NONE;
      dstm_r <= MAP_NONE;
      pat_r <= PAT_NONE;
      mask_r <= MASK_OFF;
      draw_r <= DRAW_ALL;
      oct_r <= 3'h0;
      bad_r <= 1'b0;
    end else begin
      bg_r <= bg_nxt;
      fg_r <= fg_nxt;
      op_r <= op_nxt;
      srcm_r <= srcm_nxt;
      dstm_r <= dstm_nxt;
      pat_r <= pat_nxt;
      mask_r <= mask_nxt;
      draw_r <= draw_nxt;
      oct_r <= oct_nxt;
      bad_r <= bad_nxt;
    end
  end

  // Run control; a new load wins over a same-cycle completion
  always_comb begin
    state_nxt = state_r;
    start_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (cmd_wr && op_nxt != OP_NONE) begin
          state_nxt = ST_RUN;
          start_nxt = 1'b1;
        end
      end
      ST_RUN: begin
        if (cmd_wr && op_nxt != OP_NONE) begin
          start_nxt = 1'b1;
        end else if (op_done) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      start_r <= start_nxt;
    end
  end

  // Per-map byte order plus first-octant step mapping
  always_comb begin
    fmt_nxt[0] = map_big(map_idx(srcm_r), maploc_r);
    fmt_nxt[1] = map_big(map_idx(dstm_r), maploc_r);
    fmt_nxt[2] = 1'b0;
    case (pat_r)
      PAT_A: fmt_nxt[2] = map_big(2'h1, maploc_r);
      PAT_B: fmt_nxt[2] = map_big(2'h2, maploc_r);
      PAT_C: fmt_nxt[2] = map_big(2'h3, maploc_r);
      default: fmt_nxt[2] = 1'b0;
    endcase
    step_nxt[4] = norm_step_valid;
    // Major axis always steps; minor only on a Bresenham step
    step_nxt[3] = oct_r[0] ? norm_step_minor : 1'b1;
    step_nxt[2] = oct_r[0] ? 1'b1 : norm_step_minor;
    step_nxt[1] = oct_r[2];
    step_nxt[0] = oct_r[1];
    if (!norm_step_valid) begin
      step_nxt[3:2] = 2'b00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fmt_r <= 3'h0;
      step_r <= 5'h00;
    end else begin
      fmt_r <= fmt_nxt;
      step_r <= step_nxt;
    end
  end

  assign apt.big_endian = apt_r[`APT_BIG];
  assign apt.pel_depth = apt_r[`APT_DEPTH_HI:`APT_DEPTH_LO];

  aperture_swap u_swap (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .fmt(apt.conv),
    .wr_in_valid(apt_wr_valid),
    .wr_in_data(apt_wr_data),
    .wr_out_valid(vm_wr_valid),
    .wr_out_data(vm_wr_data),
    .rd_in_valid(vm_rd_valid),
    .rd_in_data(vm_rd_data),
    .rd_out_valid(apt_rd_valid),
    .rd_out_data(apt_rd_data)
  );

  assign readdata = rdata_r;
  assign op_start = start_r;
  assign busy = (state_r == ST_RUN);
  assign bg_source = bg_r;
  assign fg_source = fg_r;
  assign step_op = op_r;
  assign src_map = srcm_r;
  assign dst_map = dstm_r;
  assign pat_map = pat_r;
  assign mask_mode = mask_r;
  assign draw_mode = draw_r;
  assign negative_x_flag = oct_r[2];
  assign negative_y_flag = oct_r[1];
  assign axis_swap_flag = oct_r[0];
  assign src_fmt_big = fmt_r[0];
  assign dst_fmt_big = fmt_r[1];
  assign pat_fmt_big = fmt_r[2];
  assign step_valid = step_r[4];
  assign step_move_x = step_r[3];
  assign step_move_y = step_r[2];
  assign step_x_neg = step_r[1];
  assign step_y_neg = step_r[0];

  chk_start_busy: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmd_wr && byteenable == 4'hf && writedata[27:24] == 4'h8 |=> op_start && busy ##1 !op_start)
    else $error("Transfer load did not start one pulse");
  chk_bg_map: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmd_wr && byteenable[3] && writedata[31:30] == 2'h2 |=> bg_source == SRC_MAP)
    else $error("Background source not map");
  chk_fg_color: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmd_wr && byteenable[3] && writedata[29:28] == 2'h0 |=> fg_source == SRC_COLOR)
    else $error("Foreground source not color");
  chk_dst_map_c: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmd_wr && byteenable[2] && writedata[19:16] == 4'h3 |=> dst_map == MAP_C)
    else $error("Destination map C not selected");
  chk_mask_bound: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmd_wr && byteenable[0] && writedata[7:6] == 2'h1 |=> mask_mode == MASK_BOUND)
    else $error("Boundary masking not selected");
  chk_fields_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    !cmd_wr |=> $stable(step_op) && $stable(src_map) && $stable(pat_map))
    else $error("Decoded field moved without a load");
  chk_swap_step: assert property (@(posedge core_clk) disable iff (!reset_n)
    norm_step_valid && axis_swap_flag && !cmd_wr
    |=> step_valid && step_move_y && step_x_neg == negative_x_flag)
    else $error("Swapped octant step wrong");
  chk_wait_once: assert property (@(posedge core_clk) disable iff (!reset_n)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("Waitrequest held more than one cycle");
  chk_busy_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    busy && !op_done |=> busy)
    else $error("Busy dropped before completion");
  chk_fmt_system: assert property (@(posedge core_clk) disable iff (!reset_n)
    src_fmt_big |-> $past(maploc_r[`MAPLOC_SYS_LO + map_idx(src_map) - 1]))
    else $error("Format applied to video-memory map");
endmodule
`default_nettype wire

// file: pkg/apt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface apt_if;
  logic big_endian;
  logic [2:0] pel_depth;
  modport ctl (output big_endian, output pel_depth);
  modport conv (input big_endian, input pel_depth);
endinterface
`default_nettype wire

// file: pkg/pel_cfg.svh
`ifndef PEL_CFG_SVH
`define PEL_CFG_SVH

// Register byte offsets
`define OFS_CMD 8'h7c
`define OFS_APT 8'h80
`define OFS_MAPLOC 8'h84
`define OFS_STATUS 8'h88

// Reset values
`define CMD_RESET 32'h0000_0000
`define APT_RESET 8'h00
`define MAPLOC_RESET 8'h00

// Command word fields
`define CMD_BG_HI 31
`define CMD_BG_LO 30
`define CMD_FG_HI 29
`define CMD_FG_LO 28
`define CMD_STEP_HI 27
`define CMD_STEP_LO 24
`define CMD_SRC_HI 23
`define CMD_SRC_LO 20
`define CMD_DST_HI 19
`define CMD_DST_LO 16
`define CMD_PAT_HI 15
`define CMD_PAT_LO 12
`define CMD_MASK_HI 7
`define CMD_MASK_LO 6
`define CMD_DRAW_HI 5
`define CMD_DRAW_LO 4
`define CMD_NEG_X 2
`define CMD_NEG_Y 1
`define CMD_SWAP 0

// Field codes
`define SRC_CODE_COLOR 2'h0
`define SRC_CODE_MAP 2'h2
`define STEP_DSR 4'h2
`define STEP_LDR 4'h3
`define STEP_DSW 4'h4
`define STEP_LDW 4'h5
`define STEP_BLT 4'h8
`define STEP_INV 4'h9
`define STEP_FILL 4'ha
`define MAP_CODE_A 4'h1
`define MAP_CODE_B 4'h2
`define MAP_CODE_C 4'h3
`define PAT_CODE_FG 4'h8
`define PAT_CODE_SRC 4'h9
`define MASK_CODE_OFF 2'h0
`define MASK_CODE_BOUND 2'h1
`define MASK_CODE_ON 2'h2
`define DRAW_CODE_ALL 2'h0
`define DRAW_CODE_FIRST 2'h1
`define DRAW_CODE_LAST 2'h2
`define DRAW_CODE_OUTLINE 2'h3

// Aperture format control fields
`define APT_DEPTH_HI 2
`define APT_DEPTH_LO 0
`define APT_BIG 3
`define DEPTH_1 3'h0
`define DEPTH_2 3'h1
`define DEPTH_4 3'h2
`define DEPTH_8 3'h3
`define DEPTH_16 3'h4

// Map location fields: system-memory flags and byte-order flags, one per map
`define MAPLOC_SYS_LO 0
`define MAPLOC_BIG_LO 4

// Status bits
`define STAT_BUSY 0
`define STAT_BAD 1

`endif

// file: pkg/pel_pkg.sv
package pel_pkg;
  typedef enum {SRC_COLOR, SRC_MAP, SRC_BAD} src_e;
  typedef enum {OP_NONE, OP_DSR, OP_LDR, OP_DSW, OP_LDW, OP_BLT, OP_INV, OP_FILL} op_e;
  typedef enum {MAP_NONE, MAP_A, MAP_B, MAP_C} map_e;
  typedef enum {PAT_NONE, PAT_A, PAT_B, PAT_C, PAT_FG, PAT_SRC} pat_e;
  typedef enum {MASK_OFF, MASK_BOUND, MASK_ON, MASK_BAD} mask_e;
  typedef enum {DRAW_ALL, DRAW_FIRST_NULL, DRAW_LAST_NULL, DRAW_OUTLINE} draw_e;
  typedef enum {ST_IDLE, ST_RUN} run_e;
endpackage

// file: test/host_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "pel_cfg.svh"
module host_model (
  input wire logic core_clk,
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  int hang = 0;
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hf;
  end
  // Request stands until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= ~w;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest && n < 40);
    if (waitrequest) begin
      hang++;
      pel_operation_decoder_bench.report_and_stop();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    writedata <= ~d;
  endtask
  task automatic load_cmd(input logic [31:0] c);
    logic [31:0] q;
    if (c[23:20] inside {[4'h1:4'h3]} && c[19:16] inside {[4'h1:4'h3]} &&
        c[15:12] inside {[4'h1:4'h3], 4'h8, 4'h9}) begin
      xfer(1'b1, `OFS_CMD, c, q);
    end else begin
      hang++;
    end
  endtask
endmodule
`default_nettype wire

// file: test/pel_operation_decoder_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "pel_cfg.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module pel_operation_decoder_bench
  import pel_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic op_done = 1'b0;
  logic norm_step_valid = 1'b0;
  logic norm_step_minor = 1'b0;
  logic apt_wr_valid = 1'b0;
  logic vm_rd_valid = 1'b0;
  logic [31:0] apt_wr_data = 32'h0;
  logic [31:0] vm_rd_data = 32'h0;
  logic [7:0] address;
  logic [3:0] byteenable;
  logic [31:0] readdata, writedata, vm_wr_data, apt_rd_data;
  logic read, write, waitrequest, op_start, busy, vm_wr_valid, apt_rd_valid;
  logic negative_x_flag, negative_y_flag, axis_swap_flag;
  logic src_fmt_big, dst_fmt_big, pat_fmt_big;
  logic step_valid, step_move_x, step_move_y, step_x_neg, step_y_neg;
  src_e bg_source, fg_source;
  op_e step_op;
  map_e src_map, dst_map;
  pat_e pat_map;
  mask_e mask_mode;
  draw_e draw_mode;
  int checked = 0;
  int n_fail = 0;
  always #25 core_clk = ~core_clk;
  host_model host (.core_clk, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest);
  pel_operation_decoder DUT (.core_clk, .reset_n, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .op_done, .op_start, .busy,
    .bg_source, .fg_source, .step_op, .src_map, .dst_map, .pat_map, .mask_mode,
    .draw_mode, .negative_x_flag, .negative_y_flag, .axis_swap_flag, .src_fmt_big,
    .dst_fmt_big, .pat_fmt_big, .norm_step_valid, .norm_step_minor, .step_valid,
    .step_move_x, .step_move_y, .step_x_neg, .step_y_neg, .apt_wr_valid,
    .apt_wr_data, .vm_wr_valid, .vm_wr_data, .vm_rd_valid, .vm_rd_data,
    .apt_rd_valid, .apt_rd_data);
  // Busy falls on the edge that samples op_done
  task automatic finish_op;
    @(posedge core_clk);
    op_done <= 1'b1;
    @(negedge core_clk);
    `CHK(busy, 1'b1)
    @(posedge core_clk);
    op_done <= 1'b0;
    @(negedge core_clk);
    `CHK(busy, 1'b0)
  endtask
  task automatic t_decode;
    logic [3:0] steps [7] = '{`STEP_DSR, `STEP_LDR, `STEP_DSW, `STEP_LDW,
      `STEP_BLT, `STEP_INV, `STEP_FILL};
    logic [3:0] pc [8] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'h1, 4'h2, 4'h3};
    int pe [8] = '{1, 2, 3, 4, 5, 1, 2, 3};
    logic [31:0] c, q;
    logic m, sw;
    for (int i = 0; i < 8; i++) begin
      c = {i[0] ? 2'h2 : 2'h0, i[1] ? 2'h2 : 2'h0, steps[i % 7], 4'(i % 3 + 1),
        4'((i + 1) % 3 + 1), pc[i], 4'hf, 2'(i % 3), 2'(i % 4), 1'b1, 3'(i)};
      m = i[1] ^ i[2];
      sw = i[0];
      host.load_cmd(c);
      norm_step_valid <= 1'b1;
      norm_step_minor <= m;
      @(negedge core_clk);
      `CHK(op_start, 1'b1)
      `CHK(busy, 1'b1)
      `CHK(bg_source, i[0] ? SRC_MAP : SRC_COLOR)
      `CHK(fg_source, i[1] ? SRC_MAP : SRC_COLOR)
      `CHK(step_op, op_e'(i % 7 + 1))
      `CHK(src_map, map_e'(i % 3 + 1))
      `CHK(dst_map, map_e'((i + 1) % 3 + 1))
      `CHK(pat_map, pat_e'(pe[i]))
      `CHK(mask_mode, mask_e'(i % 3))
      `CHK(draw_mode, draw_e'(i % 4))
      `CHK({negative_x_flag, negative_y_flag, axis_swap_flag}, 3'(i))
      @(posedge core_clk);
      norm_step_valid <= 1'b0;
      norm_step_minor <= ~m;
      @(negedge core_clk);
      `CHK(op_start, 1'b0)
      `CHK({step_valid, step_move_x, step_move_y}, {1'b1, sw ? m : 1'b1,
        sw ? 1'b1 : m})
      `CHK({step_x_neg, step_y_neg}, {i[2], i[1]})
      finish_op();
      host.xfer(1'b0, `OFS_CMD, 32'h0, q);
      `CHK(q, c)
    end
    $display("test decode done");
  endtask
  task automatic t_maploc;
    logic [31:0] q;
    // Map A in system memory and big-endian, map B big-endian in video memory
    host.xfer(1'b1, `OFS_MAPLOC, 32'h31, q);
    host.load_cmd(32'h0512_3000);
    @(posedge core_clk);
    @(negedge core_clk);
    `CHK({src_fmt_big, dst_fmt_big, pat_fmt_big}, 3'b100)
    finish_op();
    host.load_cmd(32'h0521_1000);
    @(posedge core_clk);
    @(negedge core_clk);
    `CHK({src_fmt_big, dst_fmt_big, pat_fmt_big}, 3'b011)
    finish_op();
    $display("test maploc done");
  endtask
  task automatic t_reserved;
    logic [31:0] q;
    host.load_cmd(32'h0011_1000);
    @(posedge core_clk);
    @(negedge core_clk);
    `CHK({op_start, busy}, 2'b00)
    host.xfer(1'b0, `OFS_STATUS, 32'h0, q);
    `CHK(q[1:0], 2'b10)
    host.xfer(1'b1, 8'h40, 32'hffff_ffff, q);
    host.xfer(1'b0, 8'h40, 32'h0, q);
    `CHK(q, 32'h0)
    $display("test reserved done");
  endtask
  task automatic t_aperture;
    logic [7:0] fmt [5] = '{8'h03, 8'h0b, 8'h0c, 8'h0a, 8'h08};
    logic [31:0] ex [5] = '{32'h01234567, 32'h67452301, 32'h23016745,
      32'h76543210, 32'he6a2c480};
    logic [31:0] q;
    for (int i = 0; i < 5; i++) begin
      host.xfer(1'b1, `OFS_APT, {24'h0, fmt[i]}, q);
      host.xfer(1'b0, `OFS_APT, 32'h0, q);
      `CHK(q, {24'h0, fmt[i]})
      @(posedge core_clk);
      apt_wr_valid <= 1'b1;
      apt_wr_data <= 32'h01234567;
      vm_rd_valid <= 1'b1;
      vm_rd_data <= 32'h01234567;
      @(posedge core_clk);
      apt_wr_valid <= 1'b0;
      apt_wr_data <= 32'hfedcba98;
      vm_rd_valid <= 1'b0;
      vm_rd_data <= 32'hfedcba98;
      @(negedge core_clk);
      `CHK({vm_wr_valid, vm_wr_data}, {1'b1, ex[i]})
      `CHK({apt_rd_valid, apt_rd_data}, {1'b1, ex[i]})
    end
    $display("test aperture done");
  endtask
  task automatic report_and_stop;
    n_fail += host.hang;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    `CHK({busy, op_start}, 2'b00)
    t_decode();
    t_maploc();
    t_reserved();
    t_aperture();
    report_and_stop();
  end
endmodule
`default_nettype wire
